// File: design/pbl_defines.vh
// Register map, field positions and timing counts for the bypass/loopback control block.
// Included by the control block and the bench top; holds definitions only.
`ifndef PBL_DEFINES_VH
`define PBL_DEFINES_VH
// Register index; the bus byte address is four times it
`define PBL_IDX_LBEM 6'h18
`define PBL_ADDR_LBEM {`PBL_IDX_LBEM, 2'b00}
`define PBL_ADDR_CTRL 8'h64
`define PBL_ADDR_STAT 8'h68
`define PBL_BIT_SSD_CHK 15
`define PBL_BIT_BLK_BYP 14
`define PBL_BIT_SCR_BYP 13
`define PBL_BIT_ALN_BYP 12
`define PBL_BIT_CODEC_LOOP 11
`define PBL_BIT_RSV10 10
`define PBL_LOOP_HI 9
`define PBL_LOOP_LO 8
`define PBL_BIT_RSV7 7
`define PBL_LOOP_NORMAL 2'h0
`define PBL_LOOP_XCVR 2'h1
`define PBL_LOOP_REMOTE 2'h2
`define PBL_LOOP_RSVD 2'h3
`define PBL_BAD_NIBBLE 4'hE
`define PBL_IDLE_SYM 5'h1F
`define PBL_DEAD_TIME_US 550
`define PBL_CLK_MHZ 125
`define PBL_DEAD_CYCLES (`PBL_DEAD_TIME_US * `PBL_CLK_MHZ)
`endif

// File: design/pbl_sync2.v
// Two-flop synchroniser for a bundle of asynchronous levels.
// Assumes inputs come from pins or another clock domain.
`timescale 1ns/10ps
module pbl_sync2 #(
	parameter W = 1
) (
	ref_clk,
	srst,
	d,
	q
);
	input wire ref_clk;
	input wire srst;
	input wire [W-1:0] d;
	output reg [W-1:0] q;
	reg [W-1:0] meta_r;
	always @(posedge ref_clk) begin
		if (srst) begin
			meta_r <= {W{1'b0}};
			q <= {W{1'b0}};
		end else begin
			meta_r <= d;
			q <= meta_r;
		end
	end
endmodule

// File: design/pbl_ctrl.v
// Bypass, loopback and bad start-delimiter control of a 10/100 PHY coding layer.
// Assumes an AHB-Lite master on ref_clk, 5B symbols arriving with a symbol clock
// from the link side, and strap pins that are stable around reset.
`timescale 1ns/10ps
`include "pbl_defines.vh"
module pbl_ctrl #(
	parameter DEAD_CYCLES = `PBL_DEAD_CYCLES
) (
	ref_clk,
	srst,
	hsel,
	haddr,
	htrans,
	hwrite,
	hsize,
	hwdata,
	hready,
	hreadyout,
	hresp,
	hrdata,
	block_code_bypass_strap,
	scrambler_bypass_strap,
	alignment_bypass_strap,
	basic_mode_loopback,
	five_bit_mode,
	rx_sym_clk,
	rx_sym,
	rx_ssd_bad,
	rx_dec_nibble,
	rx_dec_err,
	rx_dec_crs,
	tx_mac_sym,
	rxd,
	rx_er,
	crs,
	serial_tx_sym,
	serial_tx_en,
	block_code_bypass,
	scrambler_bypass,
	symbol_alignment_bypass,
	ten_mbps_codec_loopback,
	xcvr_loopback_on,
	remote_loopback_on,
	internal_loopback_on
);
	input wire ref_clk;
	input wire srst;
	input wire hsel;
	input wire [31:0] haddr;
	input wire [1:0] htrans;
	input wire hwrite;
	input wire [2:0] hsize;
	input wire [31:0] hwdata;
	input wire hready;
	output wire hreadyout;
	output wire hresp;
	output reg [31:0] hrdata;
	input wire block_code_bypass_strap;
	input wire scrambler_bypass_strap;
	input wire alignment_bypass_strap;
	input wire basic_mode_loopback;
	input wire five_bit_mode;
	input wire rx_sym_clk;
	input wire [4:0] rx_sym;
	input wire rx_ssd_bad;
	input wire [3:0] rx_dec_nibble;
	input wire rx_dec_err;
	input wire rx_dec_crs;
	input wire [4:0] tx_mac_sym;
	output reg [3:0] rxd;
	output reg rx_er;
	output reg crs;
	output reg [4:0] serial_tx_sym;
	output reg serial_tx_en;
	output wire block_code_bypass;
	output wire scrambler_bypass;
	output wire symbol_alignment_bypass;
	output wire ten_mbps_codec_loopback;
	output wire xcvr_loopback_on;
	output wire remote_loopback_on;
	output wire internal_loopback_on;

	localparam ST_IDLE = 3'b001;
	localparam ST_BAD = 3'b010;
	localparam ST_IDLE1 = 3'b100;

	// Pins and the symbol clock come from outside ref_clk
	wire [13:0] sync_q;
	pbl_sync2 #(
		.W(14)
	) u_sync (
		.ref_clk(ref_clk),
		.srst(srst),
		.d({rx_sym_clk, rx_sym, rx_ssd_bad, basic_mode_loopback, five_bit_mode,
			block_code_bypass_strap, scrambler_bypass_strap, alignment_bypass_strap,
			rx_dec_err, rx_dec_crs}),
		.q(sync_q)
	);
	wire sym_clk_s = sync_q[13];
	wire [4:0] sym_s = sync_q[12:8];
	wire ssd_bad_s = sync_q[7];
	wire int_loop_s = sync_q[6];
	wire five_s = sync_q[5];
	wire strap_4b5b_s = sync_q[4];
	wire strap_scr_s = sync_q[3];
	wire strap_align_s = sync_q[2];
	wire dec_err_s = sync_q[1];
	wire dec_crs_s = sync_q[0];

	reg [3:0] nib_m_r;
	reg [3:0] nib_s_r;
	reg [4:0] txm_m_r;
	reg [4:0] txm_s_r;
	always @(posedge ref_clk) begin
		if (srst) begin
			nib_m_r <= 4'h0;
			nib_s_r <= 4'h0;
			txm_m_r <= 5'h00;
			txm_s_r <= 5'h00;
		end else begin
			nib_m_r <= rx_dec_nibble;
			nib_s_r <= nib_m_r;
			txm_m_r <= tx_mac_sym;
			txm_s_r <= txm_m_r;
		end
	end

	// Register storage
	reg ssd_chk_on_r;
	reg blk_byp_r;
	reg scr_byp_r;
	reg aln_byp_r;
	reg codec_loop_r;
	reg rsv10_r;
	reg [1:0] loop_sel_r;
	reg rsv7_r;
	reg strap_pend_r;
	reg [1:0] strap_wait_r;

	// AHB-Lite address phase capture
	reg wr_pend_r;
	reg [7:0] wr_addr_r;
	wire xfer = hsel & htrans[1] & hready;
	always @(posedge ref_clk) begin
		if (srst) begin
			wr_pend_r <= 1'b0;
			wr_addr_r <= 8'h00;
		end else begin
			wr_pend_r <= xfer & hwrite;
			if (xfer)
				wr_addr_r <= haddr[7:0];
		end
	end
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;

	wire wr_lbem = wr_pend_r & (wr_addr_r == `PBL_ADDR_LBEM);

	// Straps are caught on the third clock after reset release, once through both synchroniser stages
	always @(posedge ref_clk) begin
		if (srst) begin
			ssd_chk_on_r <= 1'b1;
			blk_byp_r <= 1'b0;
			scr_byp_r <= 1'b0;
			aln_byp_r <= 1'b0;
			codec_loop_r <= 1'b0;
			rsv10_r <= 1'b0;
			loop_sel_r <= `PBL_LOOP_NORMAL;
			rsv7_r <= 1'b0;
			strap_pend_r <= 1'b1;
			strap_wait_r <= 2'h0;
		end else if (wr_lbem) begin
			ssd_chk_on_r <= hwdata[`PBL_BIT_SSD_CHK];
			blk_byp_r <= hwdata[`PBL_BIT_BLK_BYP];
			scr_byp_r <= hwdata[`PBL_BIT_SCR_BYP];
			aln_byp_r <= hwdata[`PBL_BIT_ALN_BYP];
			codec_loop_r <= hwdata[`PBL_BIT_CODEC_LOOP];
			rsv10_r <= hwdata[`PBL_BIT_RSV10];
			loop_sel_r <= hwdata[`PBL_LOOP_HI:`PBL_LOOP_LO];
			rsv7_r <= hwdata[`PBL_BIT_RSV7];
			strap_pend_r <= 1'b0;
		end else if (strap_pend_r) begin
			strap_wait_r <= strap_wait_r + 2'h1;
			if (strap_wait_r == 2'h2) begin
				blk_byp_r <= strap_4b5b_s;
				scr_byp_r <= strap_scr_s;
				aln_byp_r <= strap_align_s;
				strap_pend_r <= 1'b0;
			end
		end
	end

	wire [15:0] lbem_val = {ssd_chk_on_r, blk_byp_r, scr_byp_r, aln_byp_r, codec_loop_r, rsv10_r,
		loop_sel_r, rsv7_r, 7'h00};

	// Loopback mode decode
	// Basic control loopback wins
	assign internal_loopback_on = int_loop_s;
	// Field decode, code 11 is normal
	assign xcvr_loopback_on = ~int_loop_s & (loop_sel_r == `PBL_LOOP_XCVR);
	assign remote_loopback_on = ~int_loop_s & (loop_sel_r == `PBL_LOOP_REMOTE);
	assign block_code_bypass = blk_byp_r;
	assign scrambler_bypass = scr_byp_r;
	assign symbol_alignment_bypass = aln_byp_r;
	assign ten_mbps_codec_loopback = codec_loop_r;

	// Dead time on entering either loopback, internal to transceiver too
	wire [1:0] loop_mode = {internal_loopback_on, xcvr_loopback_on};
	reg [1:0] loop_mode_d_r;
	reg [31:0] dead_cnt_r;
	always @(posedge ref_clk) begin
		if (srst) begin
			loop_mode_d_r <= 2'h0;
			dead_cnt_r <= 32'h0;
		end else begin
			loop_mode_d_r <= loop_mode;
			if (|(loop_mode & ~loop_mode_d_r))
				dead_cnt_r <= DEAD_CYCLES;
			else if (dead_cnt_r != 32'h0)
				dead_cnt_r <= dead_cnt_r - 32'h1;
		end
	end
	wire dead = dead_cnt_r != 32'h0;

	// Symbol clock edge found on ref_clk
	reg sym_clk_d_r;
	always @(posedge ref_clk) begin
		if (srst)
			sym_clk_d_r <= 1'b0;
		else
			sym_clk_d_r <= sym_clk_s;
	end
	wire sym_tick = sym_clk_s & ~sym_clk_d_r;

	// Bad delimiter tracking per received symbol
	reg [2:0] st_r;
	reg [2:0] st_nxt;
	wire is_idle = sym_s == `PBL_IDLE_SYM;
	always @* begin
		st_nxt = st_r;
		case (st_r)
			ST_IDLE: begin
				if (ssd_chk_on_r & ssd_bad_s)
					st_nxt = ST_BAD;
			end
			ST_BAD: begin
				if (is_idle)
					st_nxt = ST_IDLE1;
			end
			ST_IDLE1: begin
				if (is_idle)
					st_nxt = ST_IDLE;
				else
					st_nxt = ST_BAD;
			end
			default: st_nxt = ST_IDLE;
		endcase
	end
	always @(posedge ref_clk) begin
		if (srst)
			st_r <= ST_IDLE;
		else if (sym_tick)
			st_r <= st_nxt;
	end
	wire bad_evt = (st_r != ST_IDLE) & ~aln_byp_r;
	// Follows the state being entered, so the bad symbol itself is flagged
	wire bad_now = (st_nxt != ST_IDLE) & ~aln_byp_r;

	// Output stage, updated on each symbol
	always @(posedge ref_clk) begin
		if (srst) begin
			rxd <= 4'h0;
			rx_er <= 1'b0;
			crs <= 1'b0;
			serial_tx_sym <= 5'h00;
			serial_tx_en <= 1'b0;
		end else if (dead) begin
			// Quiet at once, not only at the next symbol
			rxd <= 4'h0;
			rx_er <= 1'b0;
			crs <= 1'b0;
			serial_tx_en <= 1'b0;
		end else if (sym_tick) begin
			if (bad_now) begin
				rxd <= `PBL_BAD_NIBBLE;
				rx_er <= 1'b1;
				crs <= 1'b1;
			end else if (five_s | aln_byp_r) begin
				// Transparent path: raw symbol, top bit rides on error line
				rxd <= sym_s[3:0];
				rx_er <= sym_s[4];
				crs <= dec_crs_s;
			end else begin
				rxd <= nib_s_r;
				rx_er <= dec_err_s;
				crs <= dec_crs_s;
			end
			if (remote_loopback_on)
				serial_tx_sym <= sym_s;
			else
				serial_tx_sym <= txm_s_r;
			serial_tx_en <= 1'b1;
		end
	end

	// Read data for the data phase
	always @(posedge ref_clk) begin
		if (srst)
			hrdata <= 32'h0;
		else if (xfer & ~hwrite) begin
			case (haddr[7:0])
				`PBL_ADDR_LBEM: hrdata <= {16'h0, lbem_val};
				`PBL_ADDR_STAT: hrdata <= {25'h0, dead, bad_evt, st_r, remote_loopback_on,
					xcvr_loopback_on};
				default: hrdata <= 32'h0;
			endcase
		end
	end
endmodule

// File: bench/pbl_checker.sv
// Assertions on the pbl_ctrl ports.
// Assumes straps change only under srst and no write lands in the first 6 cycles.
`timescale 1ns/10ps
module pbl_checker (
	input wire ref_clk,
	input wire srst,
	input wire block_code_bypass_strap,
	input wire scrambler_bypass_strap,
	input wire alignment_bypass_strap,
	input wire block_code_bypass,
	input wire scrambler_bypass,
	input wire symbol_alignment_bypass,
	input wire ten_mbps_codec_loopback,
	input wire xcvr_loopback_on,
	input wire remote_loopback_on,
	input wire internal_loopback_on,
	input wire serial_tx_en,
	input wire rx_er,
	input wire [3:0] rxd,
	input wire crs
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (srst);
	property p_bcs;
		$fell(srst) |-> ##6 block_code_bypass == block_code_bypass_strap;
	endproperty
	a_bcs: assert property (p_bcs) else $error("block bypass strap");
	property p_scs;
		$fell(srst) |-> ##6 scrambler_bypass == scrambler_bypass_strap;
	endproperty
	a_scs: assert property (p_scs) else $error("scrambler strap");
	property p_acs;
		$fell(srst) |-> ##6 symbol_alignment_bypass == alignment_bypass_strap;
	endproperty
	a_acs: assert property (p_acs) else $error("align strap");
	property p_tlb;
		$fell(srst) |-> !ten_mbps_codec_loopback;
	endproperty
	a_tlb: assert property (p_tlb) else $error("codec loopback reset");
	property p_one;
		!(xcvr_loopback_on && remote_loopback_on);
	endproperty
	a_one: assert property (p_one) else $error("two loopbacks");
	property p_ovr;
		internal_loopback_on |-> !xcvr_loopback_on && !remote_loopback_on;
	endproperty
	a_ovr: assert property (p_ovr) else $error("override");
	property p_dtx;
		$rose(xcvr_loopback_on) |-> ##2 !serial_tx_en [*8];
	endproperty
	a_dtx: assert property (p_dtx) else $error("tx dead time");
	property p_drx;
		$rose(internal_loopback_on) |-> ##2 (!rx_er && !crs) [*8];
	endproperty
	a_drx: assert property (p_drx) else $error("rx dead time");
	cover property (remote_loopback_on);
	cover property (xcvr_loopback_on);
	cover property (rx_er && rxd == 4'hE);
endmodule
bind pbl_ctrl pbl_checker i_pbl_checker (.*);

// File: bench/pbl_mac_model.sv
// MAC side model: a transmit symbol that changes every clock.
// Assumes ref_clk is the MAC-side clock.
`timescale 1ns/10ps
module pbl_mac_model (
	input wire ref_clk,
	input wire srst,
	output reg [4:0] tx_mac_sym = 5'h00
);
	// Always busy, so leakage in remote loopback shows
	always @(posedge ref_clk) begin
		if (srst) begin
			tx_mac_sym <= 5'h00;
		end else begin
			tx_mac_sym <= tx_mac_sym + 5'h03;
		end
	end
endmodule

// File: bench/tb_top.sv
// Bench for pbl_ctrl: AHB-Lite register tasks and link symbol stimulus.
// Assumes zero-wait bus and a short dead time parameter.
`timescale 1ns/10ps
`include "pbl_defines.vh"
module tb_top;
	logic ref_clk = 0, srst = 1, hsel = 0, hwrite = 0, rx_sym_clk = 0, rx_ssd_bad = 0;
	logic basic_mode_loopback = 0, five_bit_mode = 0, rx_dec_err = 0, rx_dec_crs = 0;
	logic block_code_bypass_strap = 1, scrambler_bypass_strap = 0, alignment_bypass_strap = 1;
	logic [31:0] haddr = 0, hwdata = 0, hrdata, rd;
	logic [1:0] htrans = 0;
	logic [2:0] hsize = 3'h2;
	logic [4:0] rx_sym = 0, tx_mac_sym, serial_tx_sym;
	logic [3:0] rx_dec_nibble = 0, rxd;
	logic hready, hreadyout, hresp, rx_er, crs, serial_tx_en, block_code_bypass;
	logic scrambler_bypass, symbol_alignment_bypass, ten_mbps_codec_loopback;
	logic xcvr_loopback_on, remote_loopback_on, internal_loopback_on;
	int fail_count = 0, comparisons = 0, cyc = 0;
	assign hready = hreadyout;
	pbl_ctrl #(.DEAD_CYCLES(20)) i_pbl_ctrl (.*);
	pbl_mac_model i_pbl_mac_model (.ref_clk(ref_clk), .srst(srst), .tx_mac_sym(tx_mac_sym));
	initial begin
		forever #4 ref_clk = ~ref_clk;
	end
	task xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= a;
		hwrite <= w;
		do @(posedge ref_clk); while (hready !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge ref_clk); while (hready !== 1'b1);
		rd = hrdata;
	endtask
	task chk(input logic [31:0] g, input logic [31:0] e);
		comparisons++;
		if (g !== e) begin
			fail_count++;
			$display("[ERR] %0t got %h exp %h", $time, g, e);
		end
	endtask
	task rc(input logic [31:0] a, input logic [31:0] e);
		xfer(1'b0, a, 32'h0);
		chk(rd, e);
	endtask
	task wr(input logic [15:0] v);
		xfer(1'b1, `PBL_ADDR_LBEM, {16'h0, v});
		@(posedge ref_clk);
	endtask
	// One symbol period of 160 ns; clock idles low
	task sym(input logic [4:0] s, input logic b);
		rx_sym <= s;
		rx_dec_nibble <= s[3:0];
		rx_ssd_bad <= b;
		repeat (10) @(posedge ref_clk);
		rx_sym_clk <= 1'b1;
		repeat (10) @(posedge ref_clk);
		rx_sym_clk <= 1'b0;
	endtask
	task results;
		$display("comparisons %0d fail_count %0d", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	// Hang guard, well above the run length
	always @(posedge ref_clk) begin
		cyc++;
		if (cyc == 6000) begin
			fail_count++;
			results;
		end
	end
	initial begin
		repeat (8) @(posedge ref_clk);
		srst <= 1'b0;
		repeat (10) @(posedge ref_clk);
		rc(`PBL_ADDR_LBEM, 32'hD000);
		chk({hresp, hreadyout}, 2'h1);
		rc(`PBL_ADDR_CTRL, 32'h0);
		wr(16'h0800);
		chk(ten_mbps_codec_loopback, 1);
		sym(5'h0B, 1'b0);
		chk(serial_tx_en, 1);
		wr(16'h0100);
		// Dead time is seen two edges after the mode change
		repeat (2) @(posedge ref_clk);
		chk({xcvr_loopback_on, serial_tx_en, rx_er}, 3'h4);
		rc(`PBL_ADDR_STAT, 32'h45);
		wr(16'h0300);
		chk({xcvr_loopback_on, remote_loopback_on}, 2'h0);
		wr(16'h0100);
		basic_mode_loopback <= 1'b1;
		repeat (6) @(posedge ref_clk);
		chk({internal_loopback_on, xcvr_loopback_on}, 2'h2);
		basic_mode_loopback <= 1'b0;
		wr(16'h0200);
		repeat (30) @(posedge ref_clk);
		repeat (3) sym(5'h0B, 1'b0);
		chk({serial_tx_en, serial_tx_sym, rxd}, 10'h2BB);
		wr(16'h8000);
		sym(5'h07, 1'b1);
		chk({crs, rx_er, rxd}, 6'h3E);
		sym(5'h1F, 1'b0);
		chk({rx_er, rxd}, 5'h1E);
		sym(5'h1F, 1'b0);
		chk({crs, rx_er}, 2'h0);
		five_bit_mode <= 1'b1;
		sym(5'h07, 1'b1);
		chk({rx_er, rxd}, 5'h1E);
		five_bit_mode <= 1'b0;
		repeat (2) sym(5'h1F, 1'b0);
		wr(16'h0000);
		sym(5'h07, 1'b1);
		chk({rx_er, rxd}, 5'h07);
		wr(16'h9000);
		sym(5'h05, 1'b1);
		chk({rx_er, rxd}, 5'h05);
		rc(`PBL_ADDR_LBEM, 32'h9000);
		// Second reset with other strap levels
		block_code_bypass_strap <= 1'b0;
		scrambler_bypass_strap <= 1'b1;
		alignment_bypass_strap <= 1'b0;
		srst <= 1'b1;
		repeat (8) @(posedge ref_clk);
		srst <= 1'b0;
		repeat (10) @(posedge ref_clk);
		rc(`PBL_ADDR_LBEM, 32'hA000);
		results;
	end
endmodule
